// ==== design/pwt_pkg.sv ====
// Package with register map, field layout, reset values and carriers of the PWM timer.
package pwt_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CYCLE = 8'h04;
    localparam logic [7:0] OFS_DUTY = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_EN = 8'h14;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h18;

    // ==========================================================
    // Field positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_POL_BIT = 1;
    localparam int CTRL_CKS_LSB = 4;
    localparam int STAT_TGT_BIT = 8;
    localparam int STAT_OUT_BIT = 9;
    localparam int IRQ_CYCLE_BIT = 0;

    // ==========================================================
    // Reset values
    localparam logic [7:0] CYCLE_RST = 8'hff;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [0:0] IRQ_RST = 1'h0;

    // ==========================================================
    // Timing: duty value transfer delay in count clock periods
    localparam logic [1:0] DUTY_DELAY = 2'h3;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Comparison target of the counter.
    typedef enum logic {
        PWT_TGT_CYCLE,
        PWT_TGT_DUTY
    } pwt_tgt_t;

    // Control register contents.
    typedef struct packed {
        logic [2:0] cks;
        logic pol;
        logic run;
    } pwt_ctrl_t;

    localparam pwt_ctrl_t CTRL_RST = '{cks: 3'h0, pol: 1'h0, run: 1'h0};

endpackage : pwt_pkg

// ==== design/pwt_timer.sv ====
// Eight-bit interval timer in PWM output mode with an AXI4-Lite register slave.
// Operation
// - The duty compare value accepts software writes while the timer runs.
// - A counter match on the cycle value clears the counter, raises the irq and drives active.
// - After start the first comparison is against the cycle value.
// - A cycle match switches comparison to the duty value.
// - A duty match drives inactive and returns comparison to the cycle value, no clear, no irq.
// - Counting starts when run enable is written 1 and stops when written 0.
// - The period is the cycle value plus one count clock periods.
// - The active part of each period is the duty value plus one count clock periods.
// - A duty write while running takes effect three count clock periods later.
// - The count clock is chosen by the three-bit count clock select field.
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps

module pwt_timer (
    // Clock, reset and freeze
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Timer outputs
    output logic pwm_output_pin,
    output logic cycle_match_irq
);

    // ==========================================================
    // State
    pwt_pkg::pwt_ctrl_t ctrl_q;
    logic [7:0] cycle_q;
    logic [7:0] duty_q;
    logic [7:0] duty_act_q;
    logic [1:0] dly_q;
    logic [7:0] cnt_q;
    logic [6:0] pre_q;
    logic act_q;
    pwt_pkg::pwt_tgt_t tgt_q;
    logic ist_q;
    logic ien_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic aw_hold_q, w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic pin_q, irq_q;

    // ==========================================================
    // Bus decode
    wire aw_hs = awvalid && awready_q;
    wire w_hs = wvalid && wready_q;
    wire do_wr = aw_hold_q && w_hold_q && !bvalid_q;
    wire wr_b0 = do_wr && wstrb_q[0];
    wire wr_ctrl = wr_b0 && (awaddr_q == pwt_pkg::OFS_CTRL);
    wire wr_cycle = wr_b0 && (awaddr_q == pwt_pkg::OFS_CYCLE);
    wire wr_duty = wr_b0 && (awaddr_q == pwt_pkg::OFS_DUTY);
    wire wr_ien = wr_b0 && (awaddr_q == pwt_pkg::OFS_IRQ_EN);
    wire wr_iclr = wr_b0 && (awaddr_q == pwt_pkg::OFS_IRQ_CLR);
    wire wr_known = (awaddr_q == pwt_pkg::OFS_CTRL) || (awaddr_q == pwt_pkg::OFS_CYCLE) ||
        (awaddr_q == pwt_pkg::OFS_DUTY) || (awaddr_q == pwt_pkg::OFS_IRQ_EN) ||
        (awaddr_q == pwt_pkg::OFS_IRQ_CLR);
    wire ar_hs = arvalid && arready_q;
    wire b_hs = bvalid_q && bready;
    wire r_hs = rvalid_q && rready;

    // New control value as written; stop is judged from it, start from the stored run bit.
    wire pwt_pkg::pwt_ctrl_t ctrl_w = '{
        cks: wdata_q[pwt_pkg::CTRL_CKS_LSB +: 3],
        pol: wdata_q[pwt_pkg::CTRL_POL_BIT],
        run: wdata_q[pwt_pkg::CTRL_RUN_BIT]};
    wire stop_now = wr_ctrl && !ctrl_w.run;

    // Read mux; unmapped and write-only addresses read zero with an error.
    wire [31:0] status_w = {22'h0, act_q, tgt_q == pwt_pkg::PWT_TGT_DUTY, cnt_q};
    wire rd_ctrl = araddr == pwt_pkg::OFS_CTRL;
    wire rd_cycle = araddr == pwt_pkg::OFS_CYCLE;
    wire rd_duty = araddr == pwt_pkg::OFS_DUTY;
    wire rd_stat = araddr == pwt_pkg::OFS_STATUS;
    wire rd_ist = araddr == pwt_pkg::OFS_IRQ_STAT;
    wire rd_ien = araddr == pwt_pkg::OFS_IRQ_EN;
    wire rd_known = rd_ctrl || rd_cycle || rd_duty || rd_stat || rd_ist || rd_ien;
    wire [31:0] rd_mux = rd_ctrl ? {25'h0, ctrl_q.cks, 2'h0, ctrl_q.pol, ctrl_q.run} :
        rd_cycle ? {24'h0, cycle_q} :
        rd_duty ? {24'h0, duty_q} :
        rd_stat ? status_w :
        rd_ist ? {31'h0, ist_q} :
        rd_ien ? {31'h0, ien_q} : 32'h0;

    // ==========================================================
    // Count clock and match decode
    // The prescaler divides aclk by two to the power of the select field.
    wire [6:0] pre_mask = 7'((8'h1 << ctrl_q.cks) - 8'h1);
    wire tick = ctrl_q.run && ((pre_q & pre_mask) == pre_mask);
    wire cyc_hit = tick && (tgt_q == pwt_pkg::PWT_TGT_CYCLE) && (cnt_q == cycle_q);
    wire duty_hit = tick && (tgt_q == pwt_pkg::PWT_TGT_DUTY) && (cnt_q == duty_act_q);

    // ==========================================================
    // Write address and data channels, taken in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else if (ce) begin
            if (aw_hs) begin
                awready_q <= 1'b0;
                aw_hold_q <= 1'b1;
                awaddr_q <= awaddr;
            end
            if (w_hs) begin
                wready_q <= 1'b0;
                w_hold_q <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (b_hs) begin
                awready_q <= 1'b1;
                wready_q <= 1'b1;
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
            end
        end
    end

    // Write response follows once both halves are held.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= pwt_pkg::RESP_OKAY;
        end else if (ce) begin
            if (do_wr) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_known ? pwt_pkg::RESP_OKAY : pwt_pkg::RESP_SLVERR;
            end else if (b_hs) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read channel answers one cycle after the address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= pwt_pkg::RESP_OKAY;
        end else if (ce) begin
            if (ar_hs) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= rd_known ? pwt_pkg::RESP_OKAY : pwt_pkg::RESP_SLVERR;
            end else if (r_hs) begin
                arready_q <= 1'b1;
                rvalid_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Software registers
    // The cycle value is stored whenever written; keeping it steady while running is up to software.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= pwt_pkg::CTRL_RST;
            cycle_q <= pwt_pkg::CYCLE_RST;
            duty_q <= pwt_pkg::DUTY_RST;
            ien_q <= pwt_pkg::IRQ_RST;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl_q <= ctrl_w;
            end
            if (wr_cycle) begin
                cycle_q <= wdata_q[7:0];
            end
            if (wr_duty) begin
                duty_q <= wdata_q[7:0];
            end
            if (wr_ien) begin
                ien_q <= wdata_q[pwt_pkg::IRQ_CYCLE_BIT];
            end
        end
    end

    // Duty transfer: a running write waits three count clocks, a stopped one lands at once.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            duty_act_q <= pwt_pkg::DUTY_RST;
            dly_q <= 2'h0;
        end else if (ce) begin
            if (wr_duty && ctrl_q.run) begin
                dly_q <= pwt_pkg::DUTY_DELAY;
            end else if (wr_duty) begin
                duty_act_q <= wdata_q[7:0];
                dly_q <= 2'h0;
            end else if (stop_now) begin
                dly_q <= 2'h0;
            end else if (tick && dly_q != 2'h0) begin
                dly_q <= dly_q - 2'h1;
                if (dly_q == 2'h1) begin
                    duty_act_q <= duty_q;
                end
            end
        end
    end

    // ==========================================================
    // Counter, compare target and output level
    // Stopping resets everything so a restart always begins at zero against the cycle value.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_q <= 7'h0;
            cnt_q <= 8'h00;
            tgt_q <= pwt_pkg::PWT_TGT_CYCLE;
            act_q <= 1'b0;
        end else if (ce) begin
            if (stop_now || !ctrl_q.run) begin
                pre_q <= 7'h0;
                cnt_q <= 8'h00;
                tgt_q <= pwt_pkg::PWT_TGT_CYCLE;
                act_q <= 1'b0;
            end else begin
                pre_q <= pre_q + 7'h1;
                if (cyc_hit) begin
                    cnt_q <= 8'h00;
                    act_q <= 1'b1;
                    tgt_q <= pwt_pkg::PWT_TGT_DUTY;
                end else if (duty_hit) begin
                    cnt_q <= cnt_q + 8'h01;
                    act_q <= 1'b0;
                    tgt_q <= pwt_pkg::PWT_TGT_CYCLE;
                end else if (tick) begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
        end
    end

    // Sticky status: a cycle match in the clearing cycle still sets the bit.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ist_q <= pwt_pkg::IRQ_RST;
            irq_q <= 1'b0;
            pin_q <= 1'b0;
        end else if (ce) begin
            if (cyc_hit) begin
                ist_q <= 1'b1;
            end else if (wr_iclr && wdata_q[pwt_pkg::IRQ_CYCLE_BIT]) begin
                ist_q <= 1'b0;
            end
            irq_q <= (ist_q || cyc_hit) && ien_q;
            pin_q <= act_q ^ ctrl_q.pol;
        end
    end

    // ==========================================================
    // Output ports
    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign pwm_output_pin = pin_q;
    assign cycle_match_irq = irq_q;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    cycle_clear_a: assert property (ce && cyc_hit && !stop_now |=> cnt_q == 8'h00 && act_q)
        else $error("Cycle match did not clear counter or go active.");
    cycle_irq_a: assert property (ce && cyc_hit |=> ist_q)
        else $error("Cycle match did not set status.");
    stopped_idle_a: assert property (!ctrl_q.run |-> cnt_q == 8'h00 && !act_q)
        else $error("Stopped timer not idle.");
    first_target_a: assert property (!ctrl_q.run |-> tgt_q == pwt_pkg::PWT_TGT_CYCLE)
        else $error("Timer not aimed at cycle value while stopped.");
    duty_switch_a: assert property (ce && cyc_hit && !stop_now |=> tgt_q == pwt_pkg::PWT_TGT_DUTY)
        else $error("Cycle match did not switch to duty.");
    duty_match_a: assert property (ce && duty_hit && !stop_now |=>
        !act_q && tgt_q == pwt_pkg::PWT_TGT_CYCLE && cnt_q == $past(cnt_q) + 8'h01 &&
        !$rose(ist_q))
        else $error("Duty match misbehaved.");
    count_step_a: assert property (ce && tick && !cyc_hit && !stop_now |=>
        cnt_q == $past(cnt_q) + 8'h01)
        else $error("Counter did not step on count clock.");
    run_write_a: assert property (ce && wr_ctrl |=> ctrl_q.run == $past(wdata_q[0]))
        else $error("Run enable not taken from write.");
    duty_delay_a: assert property (ce && wr_duty && ctrl_q.run |=> dly_q == 2'h3 &&
        duty_act_q == $past(duty_act_q))
        else $error("Running duty write did not start delay.");
    // Checker helper: run cycles since the last count clock; it expects a steady select field.
    logic [7:0] gap_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gap_q <= 8'h00;
        end else if (ce) begin
            gap_q <= (tick || stop_now || !ctrl_q.run) ? 8'h00 : gap_q + 8'h01;
        end
    end
    tick_rate_a: assert property (tick |-> gap_q == {1'b0, pre_mask})
        else $error("Count clock out of step with select.");

endmodule : pwt_timer

// ==== dv/pwt_load_model.sv ====
// Model of the circuit loaded by the PWM pin: it measures every pulse it receives while armed.
`timescale 1ns/1ps

// ==========================================================
// Pulse meter
module pwt_load_model (
    // Clock and arming
    input wire logic aclk,
    input wire logic en,
    // Observed pin
    input wire logic pin,
    // Measurement of the last full period
    output logic meas_valid,
    output logic [31:0] high_cnt,
    output logic [31:0] per_cnt
);
    logic seen_q;
    logic pin_q;
    logic [31:0] per_q;
    logic [31:0] hi_q;

    // Each rising edge closes one period; the first one only opens it, so a stale
    // history from an earlier run is never reported.
    always_ff @(posedge aclk) begin
        meas_valid <= 1'b0;
        pin_q <= pin;
        if (!en) begin
            seen_q <= 1'b0;
            per_q <= 32'h0;
            hi_q <= 32'h0;
        end else if (pin && !pin_q) begin
            meas_valid <= seen_q;
            per_cnt <= per_q;
            high_cnt <= hi_q;
            seen_q <= 1'b1;
            per_q <= 32'h1;
            hi_q <= 32'h1;
        end else begin
            per_q <= per_q + 32'h1;
            hi_q <= hi_q + {31'h0, pin};
        end
    end
endmodule : pwt_load_model

// ==== dv/eight_bit_timer_pwm_output_test.sv ====
// Self-checking testbench of the PWM timer with its bus, interrupt and pulse timing.
`timescale 1ns/1ps

// ==========================================================
// Testbench top
module eight_bit_timer_pwm_output_test;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, en_p = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, pin, irq, mv;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, hc, pc;
    logic [33:0] bus_q[$];
    logic [63:0] pw_q[$];
    int error_cnt = 0, cmp_count = 0;
    int s, n, m;

    pwt_timer pwt_timer_i (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .pwm_output_pin(pin), .cycle_match_irq(irq));
    pwt_load_model pwt_load_model_i (.aclk(aclk), .en(en_p), .pin(pin), .meas_valid(mv),
        .high_cnt(hc), .per_cnt(pc));

    // The clock runs at 25 MHz.
    initial begin
        forever #20 aclk = ~aclk;
    end

    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("TB: %0d comparisons, %0d mismatches", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    task automatic tmo();
        error_cnt++;
        $display("Error wait expected completion seen timeout");
        results();
    endtask : tmo

    // ==========================================================
    // Bus master tasks; each notes its expected response before it starts.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        bus_q.push_back({er, 32'h0});
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        for (k = 0; k < 200; k++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (k == 200) tmo();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        int k;
        bus_q.push_back(e);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (k = 0; k < 200; k++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (k == 200) tmo();
    endtask : rd

    // Waits until every noted pulse has been measured; a long count scale needs a wide bound.
    task automatic wait_empty();
        int k;
        for (k = 0; k < 40000 && pw_q.size() > 0; k++) @(posedge aclk);
        if (k == 40000) tmo();
    endtask : wait_empty

    task automatic wait_meas(input int cnt);
        int k;
        for (k = 0; k < 40000 && cnt > 0; k++) begin
            @(posedge aclk);
            if (mv) cnt--;
        end
        if (k == 40000) tmo();
    endtask : wait_meas

    // ==========================================================
    // Result watcher: takes the oldest note whenever a response or a pulse appears.
    always @(posedge aclk) begin
        if (aresetn && bvalid && bready) check("bresp", {bresp, 32'h0}, bus_q.pop_front());
        if (aresetn && rvalid && rready) check("read", {rresp, rdata}, bus_q.pop_front());
        if (mv && pw_q.size() > 0) begin
            check("pulse high,period", {hc, pc}, pw_q.pop_front());
        end
    end

    // ==========================================================
    // Main sequence.
    initial begin
        void'($urandom(32'h1126));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(pwt_pkg::OFS_CTRL, 34'h0);
        rd(pwt_pkg::OFS_CYCLE, {2'h0, 24'h0, pwt_pkg::CYCLE_RST});
        rd(pwt_pkg::OFS_DUTY, {2'h0, 24'h0, pwt_pkg::DUTY_RST});
        // A write with the low byte lane off must leave the register alone.
        wstrb <= 4'he;
        wr(pwt_pkg::OFS_DUTY, 32'h55, pwt_pkg::RESP_OKAY);
        wstrb <= 4'hf;
        rd(pwt_pkg::OFS_DUTY, {2'h0, 24'h0, pwt_pkg::DUTY_RST});
        rd(pwt_pkg::OFS_IRQ_STAT, 34'h0);
        rd(8'h1c, {pwt_pkg::RESP_SLVERR, 32'h0});
        wr(8'h1c, 32'h1, pwt_pkg::RESP_SLVERR);
        rd(pwt_pkg::OFS_IRQ_CLR, {pwt_pkg::RESP_SLVERR, 32'h0});
        wr(pwt_pkg::OFS_IRQ_EN, 32'h1, pwt_pkg::RESP_OKAY);
        $display("TB: register map test done");
        // Every count clock choice with a random period; long scales get short periods.
        for (s = 0; s < 8; s++) begin
            n = (s < 4) ? 4 + $urandom % 252 : 4 + $urandom % 12;
            m = $urandom % n;
            wr(pwt_pkg::OFS_CYCLE, n, pwt_pkg::RESP_OKAY);
            wr(pwt_pkg::OFS_DUTY, m, pwt_pkg::RESP_OKAY);
            en_p <= 1'b1;
            wr(pwt_pkg::OFS_CTRL, (s << 4) | 1, pwt_pkg::RESP_OKAY);
            repeat (2) pw_q.push_back({(m + 1) << s, (n + 1) << s});
            wait_empty();
            wr(pwt_pkg::OFS_CTRL, 32'h0, pwt_pkg::RESP_OKAY);
            en_p <= 1'b0;
            rd(pwt_pkg::OFS_STATUS, 34'h0);
            check("pin", pin, 1'b0);
            rd(pwt_pkg::OFS_IRQ_STAT, 34'h1);
            check("irq", irq, 1'b1);
            wr(pwt_pkg::OFS_IRQ_EN, 32'h0, pwt_pkg::RESP_OKAY);
            repeat (2) @(posedge aclk);
            check("irq", irq, 1'b0);
            wr(pwt_pkg::OFS_IRQ_EN, 32'h1, pwt_pkg::RESP_OKAY);
            wr(pwt_pkg::OFS_IRQ_CLR, 32'h1, pwt_pkg::RESP_OKAY);
            rd(pwt_pkg::OFS_IRQ_STAT, 34'h0);
            check("irq", irq, 1'b0);
            $display("TB: pulse test with scale %0d done", s);
        end
        // Duty rewrite while running; pulses that straddle the change are skipped.
        wr(pwt_pkg::OFS_CYCLE, 32'd20, pwt_pkg::RESP_OKAY);
        wr(pwt_pkg::OFS_DUTY, 32'd3, pwt_pkg::RESP_OKAY);
        en_p <= 1'b1;
        wr(pwt_pkg::OFS_CTRL, 32'h1, pwt_pkg::RESP_OKAY);
        pw_q.push_back({32'd4, 32'd21});
        wait_empty();
        wr(pwt_pkg::OFS_DUTY, 32'd12, pwt_pkg::RESP_OKAY);
        wait_meas(2);
        repeat (2) pw_q.push_back({32'd13, 32'd21});
        wait_empty();
        $display("TB: duty rewrite test done");
        // Thirty frozen cycles inside the active phase stretch both counts of that pulse.
        ce <= 1'b0;
        repeat (30) @(posedge aclk);
        ce <= 1'b1;
        pw_q.push_back({32'd43, 32'd51});
        pw_q.push_back({32'd13, 32'd21});
        wait_empty();
        $display("TB: clock enable test done");
        // Inverted polarity: the meter now sees the inactive phase as its high time.
        wr(pwt_pkg::OFS_CTRL, 32'h3, pwt_pkg::RESP_OKAY);
        wait_meas(2);
        repeat (2) pw_q.push_back({32'd8, 32'd21});
        wait_empty();
        wr(pwt_pkg::OFS_CTRL, 32'h2, pwt_pkg::RESP_OKAY);
        en_p <= 1'b0;
        repeat (2) @(posedge aclk);
        check("pin", pin, 1'b1);
        $display("TB: polarity test done");
        results();
    end
endmodule : eight_bit_timer_pwm_output_test
